// >>> pkg/sw_clk_pkg.sv
package sw_clk_pkg;

    // Clock rate and derived rates
    localparam int unsigned CLK_NS   = 100;
    localparam int unsigned CLK_KHZ  = 1000000 / CLK_NS;
    localparam int unsigned STEP_KHZ = 50;
    localparam int unsigned STEP_DIV = CLK_KHZ / STEP_KHZ;

    // Field widths
    localparam int unsigned STEP_W = 5;
    localparam int unsigned CNT_W  = 8;
    localparam int unsigned CODE_W = 4;
    localparam int unsigned SYNC_N = 3;

    // Frequency limits: top 50 kHz step count, top resistor code, shortest period in main clock cycles
    localparam logic [STEP_W-1:0] MAX_STEPS  = 5'h1E;
    localparam logic [CODE_W-1:0] MAX_CODE   = 4'hE;
    localparam logic [CNT_W-1:0]  MIN_PERIOD = 8'h02;

    // Sync presence window, longest time rounds down
    localparam int unsigned SYNC_WIN_NS  = 20000;
    localparam int unsigned SYNC_WIN_CYC = SYNC_WIN_NS / CLK_NS;
    localparam logic [CNT_W-1:0] SYNC_WIN = CNT_W'(SYNC_WIN_CYC);

    // Resistor code to default frequency, lowest resistor first
    localparam int unsigned FREQ_KHZ [0:14] = '{300, 400, 500, 550, 600, 650, 700, 750,
                                                800, 850, 900, 950, 1000, 1250, 1500};

    // Phase configuration command values
    localparam logic [15:0] PH_STANDALONE = 16'h0000;
    localparam logic [15:0] PH_MASTER     = 16'h0100;
    localparam logic [15:0] PH_SLAVE_IN   = 16'h0120;
    localparam logic [15:0] PH_SLAVE_ANTI = 16'h0121;

    // Switching configuration modes
    typedef enum logic [1:0] {
        MODE_STANDALONE,
        MODE_MASTER,
        MODE_SLAVE_IN,
        MODE_SLAVE_ANTI
    } mode_e;

    // Default steps for a sensed resistor code
    function automatic logic [STEP_W-1:0] code_steps(input logic [CODE_W-1:0] code);
        logic [CODE_W-1:0] c;
        c = (code > MAX_CODE) ? MAX_CODE : code;
        return STEP_W'(FREQ_KHZ[c] / STEP_KHZ);
    endfunction

endpackage

// >>> logic/link_edge_toggle.sv
`timescale 1ns/100ps
// Flips once per rising edge of the incoming sync clock
module link_edge_toggle (
    // Link side
    input  wire logic sync_clk,
    // Reset, applied asynchronously in this domain
    input  wire logic rst,
    // Toggle level towards the main clock domain
    output logic      edge_tog
);

    typedef struct packed {
        logic tog;
    } link_s;

    link_s l_r;
    link_s l_nxt;

    // Next toggle value
    always_comb begin
        l_nxt     = l_r;
        l_nxt.tog = ~l_r.tog;
    end

    // Link domain register; reset loads a constant
    always_ff @(posedge sync_clk or posedge rst) begin
        if (rst) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign edge_tog = l_r.tog;

endmodule // link_edge_toggle

// >>> logic/switching_clock_sync_select.sv
`timescale 1ns/100ps
// Contract
// RQ1: Sensed resistor code maps to fifteen default frequencies, 300 to 1500 kHz.
// RQ2: Resistor is sampled once after power up; the default then holds.
// RQ3: A command replaces the frequency in 50 kHz steps.
// RQ4: Four modes exist; master mode is the state after reset.
// RQ5: Phase configuration command moves master to standalone or either slave mode.
// RQ6: Standalone free-runs and releases the sync pin.
// RQ7: Master drives a 50 % square wave in phase with switching; odd periods give a high time below 50 %.
// RQ8: Slave in phase adopts external clock and aligns; otherwise self-timed.
// RQ9: Slave anti-phase adopts external clock, switches 180 degrees away.
// RQ10: A slave fed by a master uses the master's resistor value.
// RQ11: External clock presence is judged by edges within a window; loss falls back.
module switching_clock_sync_select (
    // Main clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst,
    // Incoming sync clock from the neighbour
    input  wire logic                              sync_clk,
    // Resistor sense result during power up
    input  wire logic                              rsense_valid,
    input  wire logic [sw_clk_pkg::CODE_W-1:0]     rsense_code,
    // Frequency override command
    input  wire logic                              freq_cmd_valid,
    input  wire logic [sw_clk_pkg::STEP_W-1:0]     freq_cmd_steps,
    // Phase configuration command
    input  wire logic                              phase_cmd_valid,
    input  wire logic [15:0]                       phase_cmd_value,
    // Switching timing towards the power stage
    output logic                                   sw_clk,
    // Sync pin drive
    output logic                                   sync_out,
    output logic                                   sync_oe,
    // Status
    output sw_clk_pkg::mode_e                      mode,
    output logic [sw_clk_pkg::STEP_W-1:0]          active_steps,
    output logic                                   sensed_done,
    output logic                                   ext_locked
);

    typedef struct packed {
        logic                          sensed;
        logic                          ovr;
        logic [sw_clk_pkg::STEP_W-1:0] steps;
        sw_clk_pkg::mode_e             mode;
        logic [sw_clk_pkg::SYNC_N-1:0] sync_sh;
        logic                          acc;
        logic                          seen;
        logic                          locked;
        logic [sw_clk_pkg::CNT_W-1:0]  gap;
        logic [sw_clk_pkg::CNT_W-1:0]  meas;
        logic [sw_clk_pkg::CNT_W-1:0]  cnt;
        logic                          aligned;
        logic                          sw;
        logic                          sync_out;
        logic                          sync_oe;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic   edge_tog;

    // Link domain edge toggle
    link_edge_toggle u_link (
        .sync_clk (sync_clk),
        .rst      (rst),
        .edge_tog (edge_tog)
    );

    // Next state of the whole block
    always_comb begin
        logic                         ext_edge;
        logic                         slave;
        logic [sw_clk_pkg::CNT_W-1:0] period;
        logic [sw_clk_pkg::CNT_W-1:0] half;
        ext_edge = 1'b0;
        slave    = 1'b0;
        period   = '0;
        half     = '0;
        s_nxt    = s_r;

        // Sample the resistor once; its steps are not loaded if a command already overrode them
        if (rsense_valid && !s_r.sensed) begin
            s_nxt.sensed = 1'b1;                                   // [RQ2]
            if (!s_r.ovr) begin
                s_nxt.steps = sw_clk_pkg::code_steps(rsense_code); // [RQ1]
            end
        end

        // Frequency override in 50 kHz steps, zero and above range ignored
        if (freq_cmd_valid && freq_cmd_steps != '0 && freq_cmd_steps <= sw_clk_pkg::MAX_STEPS) begin
            s_nxt.steps = freq_cmd_steps;                          // [RQ3]
            s_nxt.ovr   = 1'b1;
        end

        // Mode change by phase configuration; unknown values ignored
        if (phase_cmd_valid) begin
            unique case (phase_cmd_value)
                sw_clk_pkg::PH_STANDALONE: s_nxt.mode = sw_clk_pkg::MODE_STANDALONE; // [RQ5]
                sw_clk_pkg::PH_MASTER:     s_nxt.mode = sw_clk_pkg::MODE_MASTER;
                sw_clk_pkg::PH_SLAVE_IN:   s_nxt.mode = sw_clk_pkg::MODE_SLAVE_IN;   // [RQ5]
                sw_clk_pkg::PH_SLAVE_ANTI: s_nxt.mode = sw_clk_pkg::MODE_SLAVE_ANTI; // [RQ5]
                default:                   s_nxt.mode = s_r.mode;
            endcase
        end
        slave = (s_nxt.mode == sw_clk_pkg::MODE_SLAVE_IN) || (s_nxt.mode == sw_clk_pkg::MODE_SLAVE_ANTI);

        // Toggle synchroniser; a change counts when stages two and three agree
        s_nxt.sync_sh = {s_r.sync_sh[1:0], edge_tog};
        if (s_r.sync_sh[1] == s_r.sync_sh[2] && s_r.sync_sh[2] != s_r.acc) begin
            s_nxt.acc = s_r.sync_sh[2];
            ext_edge  = 1'b1;
        end

        // Presence detection and period measurement
        s_nxt.aligned = 1'b0;
        if (!slave) begin
            s_nxt.seen   = 1'b0;
            s_nxt.locked = 1'b0;
            s_nxt.gap    = '0;
        end else if (ext_edge) begin
            // An edge after the window has run out restarts the search
            s_nxt.locked = 1'b0;                                   // [RQ11]
            if (s_r.seen && s_r.gap < sw_clk_pkg::SYNC_WIN) begin
                s_nxt.locked = 1'b1;                               // [RQ11]
                s_nxt.meas   = s_r.gap + 8'h01;
            end
            s_nxt.seen = 1'b1;
            s_nxt.gap  = '0;
        end else if (s_r.gap >= sw_clk_pkg::SYNC_WIN) begin
            s_nxt.seen   = 1'b0;
            s_nxt.locked = 1'b0;                                   // [RQ11]
        end else begin
            s_nxt.gap = s_r.gap + 8'h01;
        end

        // Switching period: adopted when locked, own frequency otherwise
        if (s_nxt.locked) begin
            period = s_nxt.meas;                                   // [RQ8] [RQ9]
        end else begin
            period = (s_nxt.steps == '0) ? '0 : sw_clk_pkg::CNT_W'(sw_clk_pkg::STEP_DIV / s_nxt.steps);
        end
        if (period < sw_clk_pkg::MIN_PERIOD) begin
            period = sw_clk_pkg::MIN_PERIOD;
        end
        half = period >> 1;

        // Phase counter, realigned on each external edge when locked
        if (s_nxt.locked && ext_edge) begin
            s_nxt.aligned = 1'b1;
            s_nxt.cnt     = (s_nxt.mode == sw_clk_pkg::MODE_SLAVE_ANTI) ? half : '0; // [RQ8] [RQ9]
        end else if (s_r.cnt + 8'h01 >= period) begin
            s_nxt.cnt = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end

        // Switching timing runs only once the resistor has been sensed
        s_nxt.sw = s_nxt.sensed && (s_nxt.cnt < half);

        // Sync pin: only a master drives it, echoing its switching
        s_nxt.sync_oe  = s_nxt.sensed && (s_nxt.mode == sw_clk_pkg::MODE_MASTER);  // [RQ6] [RQ7]
        s_nxt.sync_out = s_nxt.sync_oe && s_nxt.sw;                                 // [RQ7]
    end

    // State register; reset lands in master mode
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r      <= '0;
            s_r.mode <= sw_clk_pkg::MODE_MASTER;                   // [RQ4]
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign sw_clk       = s_r.sw;
    assign sync_out     = s_r.sync_out;
    assign sync_oe      = s_r.sync_oe;
    assign mode         = s_r.mode;
    assign active_steps = s_r.steps;
    assign sensed_done  = s_r.sensed;
    assign ext_locked   = s_r.locked;

    // Lowest resistor code selects the first table entry
    table_map_a: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
        $past(rsense_valid) && !$past(s_r.sensed) && !$past(s_r.ovr) && !$past(freq_cmd_valid)
            && $past(rsense_code) == 4'h0 |-> s_r.steps == 5'h06)
        else $error("lowest resistor did not select 300 kHz");

    // Default holds once sensed
    sense_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
        s_r.sensed && !freq_cmd_valid |=> $stable(s_r.steps) && s_r.sensed)
        else $error("frequency changed after sensing without a command");

    // Override takes the commanded steps
    override_a: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
        freq_cmd_valid && freq_cmd_steps != 5'h00 && freq_cmd_steps <= 5'h1E
            |=> s_r.steps == $past(freq_cmd_steps) && s_r.ovr)
        else $error("frequency command not applied");

    // Master after reset
    reset_master_a: assert property (@(posedge mclk) // [RQ4]
        $past(rst) && !rst |-> s_r.mode == sw_clk_pkg::MODE_MASTER)
        else $error("mode after reset is not master");

    // Mode write of the standalone code
    mode_write_a: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
        phase_cmd_valid && phase_cmd_value == 16'h0000 |=> s_r.mode == sw_clk_pkg::MODE_STANDALONE)
        else $error("standalone command not applied");

    // Standalone releases the pin
    pin_release_a: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
        s_r.mode != sw_clk_pkg::MODE_MASTER |-> !s_r.sync_oe && !s_r.sync_out)
        else $error("sync pin driven outside master mode");

    // Master echoes switching on the pin
    master_echo_a: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
        s_r.mode == sw_clk_pkg::MODE_MASTER && s_r.sensed |-> s_r.sync_oe && s_r.sync_out == s_r.sw)
        else $error("master sync output not following switching");

    // In-phase alignment on an external edge
    phase_in_a: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
        s_r.aligned && s_r.mode == sw_clk_pkg::MODE_SLAVE_IN |-> s_r.sw && s_r.cnt == 8'h00)
        else $error("in-phase slave not aligned to external edge");

    // Anti-phase alignment on an external edge
    phase_anti_a: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
        s_r.aligned && s_r.mode == sw_clk_pkg::MODE_SLAVE_ANTI |-> !s_r.sw && s_r.cnt == (s_r.meas >> 1))
        else $error("anti-phase slave not half a period away");

    // Loss of edges drops the lock
    sync_loss_a: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
        s_r.gap >= 8'hC8 && !s_r.aligned |=> !s_r.locked || s_r.gap == 8'h00)
        else $error("lock kept after edge window expired");

endmodule // switching_clock_sync_select

// >>> verification/sync_neighbour.sv
`timescale 1ns/100ps
// Neighbour converter in master mode feeding the sync pin
module sync_neighbour #(
    parameter int unsigned DIV = 64
) (
    // Enable from the bench
    input  wire logic en,
    // Sync clock towards the block
    output logic      sync_clk
);
    logic base_clk;
    int   cnt;

    // Own 32 ns oscillator, free of the main clock
    initial begin
        base_clk = 1'b0;
        #7;
        forever #16 base_clk = ~base_clk;
    end

    // Square wave at the shared resistor rate, low while off
    always @(posedge base_clk) begin
        if (!en) begin
            cnt      <= 0;
            sync_clk <= 1'b0;
        end else begin
            cnt      <= (cnt == DIV - 1) ? 0 : cnt + 1;
            sync_clk <= (cnt < DIV / 2);
        end
    end
endmodule // sync_neighbour

// >>> verification/switching_clock_sync_select_tb.sv
`timescale 1ns/100ps
// Bench for switching frequency and sync selection
module switching_clock_sync_select_tb;
    logic                          mclk;
    logic                          rst;
    logic                          sync_clk;
    logic                          nb_en;
    logic                          rsense_valid;
    logic [sw_clk_pkg::CODE_W-1:0] rsense_code;
    logic                          freq_cmd_valid;
    logic [sw_clk_pkg::STEP_W-1:0] freq_cmd_steps;
    logic                          phase_cmd_valid;
    logic [15:0]                   phase_cmd_value;
    logic                          sw_clk;
    logic                          sync_out;
    logic                          sync_oe;
    sw_clk_pkg::mode_e             mode;
    logic [sw_clk_pkg::STEP_W-1:0] active_steps;
    logic                          sensed_done;
    logic                          ext_locked;
    int                            err_count;
    int                            cmp_count;
    // Defaults in 50 kHz steps, lowest resistor first
    int exp_steps [0:14] = '{6, 8, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 25, 30};

    // Main clock
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    switching_clock_sync_select DUT (
        .mclk(mclk), .rst(rst), .sync_clk(sync_clk),
        .rsense_valid(rsense_valid), .rsense_code(rsense_code),
        .freq_cmd_valid(freq_cmd_valid), .freq_cmd_steps(freq_cmd_steps),
        .phase_cmd_valid(phase_cmd_valid), .phase_cmd_value(phase_cmd_value),
        .sw_clk(sw_clk), .sync_out(sync_out), .sync_oe(sync_oe), .mode(mode),
        .active_steps(active_steps), .sensed_done(sensed_done), .ext_locked(ext_locked)
    );

    sync_neighbour NB (.en(nb_en), .sync_clk(sync_clk));

    // Verdict and end of run
    task automatic results;
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Bounded wait for a level on sw_clk (0) or ext_locked (1)
    task automatic wait_lvl(input int sel, input logic v, inout int n);
        int k;
        for (k = 0; k < 600 && ((sel == 0) ? sw_clk : ext_locked) !== v; k++)
            tick(1);
        if (k == 600) begin
            chk(1'b0, "wait ran out");
            results();
        end
        n += k;
    endtask

    // One full period of sw_clk: high time and period
    task automatic period(output int h, output int p);
        int n;
        n = 0;
        wait_lvl(0, 1'b0, n);
        wait_lvl(0, 1'b1, n);
        h = 0;
        wait_lvl(0, 1'b0, h);
        p = h;
        wait_lvl(0, 1'b1, p);
    endtask

    task automatic do_reset;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        tick(1);
    endtask

    task automatic sense(input logic [3:0] c);
        rsense_code = c;
        rsense_valid = 1'b1;
        tick(1);
        rsense_valid = 1'b0;
        tick(1);
    endtask

    task automatic freq(input logic [4:0] s);
        freq_cmd_steps = s;
        freq_cmd_valid = 1'b1;
        tick(1);
        freq_cmd_valid = 1'b0;
        tick(1);
    endtask

    task automatic phase(input logic [15:0] v);
        phase_cmd_value = v;
        phase_cmd_valid = 1'b1;
        tick(1);
        phase_cmd_valid = 1'b0;
        tick(1);
    endtask

    // Every resistor code once, codes above the table clamp
    task automatic s_table;
        for (int c = 0; c < 16; c++) begin
            do_reset();
            chk(mode === sw_clk_pkg::MODE_MASTER && sync_oe === 1'b0, "reset state");
            chk(sensed_done === 1'b0, "sensed before sample");
            sense(4'(c));
            chk(active_steps === 5'(exp_steps[(c > 14) ? 14 : c]), "default frequency");
            chk(sensed_done === 1'b1, "sample not taken");
        end
        sense(4'h0);
        chk(active_steps === 5'h1E, "second sense taken");
    endtask

    // Own frequency override and master sync wave
    task automatic s_master;
        int h;
        int p;
        chk(sync_oe === 1'b1, "master not driving");
        freq(5'h0A);
        chk(active_steps === 5'h0A, "override lost");
        freq(5'h00);
        freq(5'h1F);
        chk(active_steps === 5'h0A, "bad step taken");
        period(h, p);
        chk(p == 20 && h == 10, "master period or duty");
        for (int i = 0; i < 40; i++) begin
            chk(sync_out === sw_clk, "sync wave not with switching");
            tick(1);
        end
    endtask

    // Standalone releases the pin, unknown value ignored
    task automatic s_phase;
        int h;
        int p;
        phase(16'h0000);
        chk(mode === sw_clk_pkg::MODE_STANDALONE && sync_oe === 1'b0, "standalone");
        chk(sync_out === 1'b0, "pin driven in standalone");
        period(h, p);
        chk(p == 20, "standalone rate");
        phase(16'h0055);
        chk(mode === sw_clk_pkg::MODE_STANDALONE, "unknown value taken");
        phase(16'h0100);
        chk(mode === sw_clk_pkg::MODE_MASTER && sync_oe === 1'b1, "back to master");
    endtask

    // Slave: lock, adopt rate, phase, then fall back
    task automatic s_slave(input logic [15:0] v, input sw_clk_pkg::mode_e m, input logic lvl);
        int h;
        int p;
        int n;
        freq(5'h05);
        phase(v);
        chk(mode === m && sync_oe === 1'b0, "slave mode");
        chk(sync_out === 1'b0, "pin driven as slave");
        nb_en = 1'b1;
        n = 0;
        wait_lvl(1, 1'b1, n);
        period(h, p);
        chk(p >= 19 && p <= 22, "rate not adopted");
        for (n = 0; n < 60 && sync_clk !== 1'b0; n++)
            tick(1);
        for (h = 0; h < 60 && n < 60 && sync_clk !== 1'b1; h++)
            tick(1);
        // A stuck neighbour clock ends the run
        if (n == 60 || h == 60) begin
            chk(1'b0, "sync clock stuck");
            results();
        end
        tick(6);
        chk(sw_clk === lvl, "switching phase");
        nb_en = 1'b0;
        n = 0;
        wait_lvl(1, 1'b0, n);
        chk(n <= 220, "loss not seen");
        period(h, p);
        chk(p == 40, "no self-timed fallback");
    endtask

    initial begin
        err_count = 0;
        cmp_count = 0;
        nb_en = 1'b0;
        rsense_valid = 1'b0;
        rsense_code = 4'h0;
        freq_cmd_valid = 1'b0;
        freq_cmd_steps = 5'h00;
        phase_cmd_valid = 1'b0;
        phase_cmd_value = 16'h0000;
        s_table();
        s_master();
        s_phase();
        s_slave(16'h0120, sw_clk_pkg::MODE_SLAVE_IN, 1'b1);
        s_slave(16'h0121, sw_clk_pkg::MODE_SLAVE_ANTI, 1'b0);
        results();
    end
endmodule // switching_clock_sync_select_tb
